// *** rtl/mcs_top.sv ***
// motor command shaping and safety logic, two channels
// assumes avalon-mm master on i_clk_sys; switches and general inputs are asynchronous, motor-run flags share the clock
// Function
// (R1) each channel has its own five-way curve select
// (R2) curve codes: 0 linear default, 1/2 exponential, 3/4 logarithmic
// (R3) linear curve: output proportional to command past the deadband; the code has no deadband and passes the command unchanged
// (R4) exponential: slow near center, steeper to full, full at extreme
// (R5) logarithmic: steep near center, flattening toward the extreme
// (R6) curve shapes forward and reverse symmetrically
// (R7) direction trim is multiplicative, plus or minus 5.25 percent, 0.75 steps
// (R8) trim 0..14, 7 neutral; below 7 slows forward
// (R9) trim favouring forward slows reverse instead
// (R10) trim follows the curve and is bypassed in closed loop
// (R11) aux output on when enabled and either motor runs
// (R12) both front buttons together remove motor power at once
// (R13) emergency stop latches until reset
// (R14) safety input: none, emergency stop on closed, or inverted detect
// (R15) inversion only in mixed mode with inverted detect selected
// (R16) tilt closed means inverted; accepted closed reverses commands
// (R17) tilt change accepted after 0.5 s stable; bounce restarts
// (R18) first general input ignored when encoder installed
// (R19) general inputs ignored by default; may drive aux or gate power
// (R20) aux mode: output on while input low
// (R21) gate mode: power enabled only while input low
`timescale 1ns/1ps

module mcs_top
    import mcs_pkg::*;
#(
    parameter int TILT_CYC = MCS_TILT_CYC,
    parameter int CMD_W = 12
) (
    input wire logic i_clk_sys, // system clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic [3:0] i_avs_address, // byte address
    input wire logic i_avs_read, // read strobe
    input wire logic i_avs_write, // write strobe
    input wire logic [31:0] i_avs_writedata, // write data
    input wire logic [3:0] i_avs_byteenable, // byte lanes
    output logic [31:0] o_avs_readdata, // read data
    output logic o_avs_waitrequest, // stall
    input wire logic i_btn_prog_n, // front button, low pressed
    input wire logic i_btn_set_n, // front button, low pressed
    input wire logic i_safety_tilt_input, // high = switch closed
    input wire logic i_gpi_e, // general input e
    input wire logic i_gpi_f, // general input f
    input wire logic i_mot1_run, // motor 1 running, same clock
    input wire logic i_mot2_run, // motor 2 running, same clock
    output logic signed [CMD_W-1:0] o_cmd1, // shaped command 1
    output logic signed [CMD_W-1:0] o_cmd2, // shaped command 2
    output logic o_aux_out, // auxiliary output
    output logic o_power_en, // power stage enable
    output logic o_estop // emergency stop latched
);

    localparam int MAG_W = CMD_W - 1;
    localparam int CW = $clog2(TILT_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // functions

    // response curve on a magnitude, full scale maps to full scale
    function automatic logic [MAG_W-1:0] shape(input logic [2:0] sel,
                                               input logic [MAG_W-1:0] m);
        logic [MAG_W-1:0] full;
        logic [2*MAG_W-1:0] sq;
        logic [MAG_W-1:0] x2;
        logic [MAG_W-1:0] inv;
        logic [2*MAG_W-1:0] isq;
        logic [MAG_W-1:0] l2;
        logic [2*MAG_W-1:0] mw;
        logic [2*MAG_W-1:0] iw;
        full = '1;
        // m*(m+1): both ends map exactly
        mw = (2*MAG_W)'(m);
        sq = mw * (mw + 1'b1);
        x2 = sq[2*MAG_W-1:MAG_W];
        inv = full - m;
        iw = (2*MAG_W)'(inv);
        isq = iw * (iw + 1'b1);
        l2 = full - isq[2*MAG_W-1:MAG_W];
        case (sel)
            MCS_CRV_LIN: shape = m; // R3
            MCS_CRV_EXP_STRONG: shape = x2; // R4
            MCS_CRV_EXP_NORMAL: shape = MAG_W'(({1'b0, m} + {1'b0, x2}) >> 1); // R4
            MCS_CRV_LOG_NORMAL: shape = MAG_W'(({1'b0, m} + {1'b0, l2}) >> 1); // R5
            MCS_CRV_LOG_STRONG: shape = l2; // R5
            default: shape = m;
        endcase
    endfunction

    // full command path of one channel
    function automatic logic signed [CMD_W-1:0] chan(input logic signed [CMD_W-1:0] c,
                                                     input logic [2:0] sel,
                                                     input logic [3:0] trim,
                                                     input logic cloop,
                                                     input logic inv);
        logic neg;
        logic [MAG_W-1:0] mag;
        logic [MAG_W-1:0] s;
        logic [12:0] gain;
        logic [MAG_W+12:0] prod;
        logic [MAG_W-1:0] t;
        logic signed [CMD_W-1:0] r;
        neg = c[CMD_W-1];
        // saturate the most negative code so both halves are symmetric
        mag = neg ? ((c == {1'b1, {MAG_W{1'b0}}}) ? '1 : MAG_W'(-c)) : c[MAG_W-1:0];
        s = shape(sel, mag); // R6
        gain = MCS_GAIN_FULL;
        if (trim < MCS_TRIM_RST && !neg) begin
            gain = 13'(MCS_GAIN_FULL - 13'(MCS_TRIM_STEP * (MCS_TRIM_RST - trim))); // R8
        end else if (trim > MCS_TRIM_RST && neg) begin
            gain = 13'(MCS_GAIN_FULL - 13'(MCS_TRIM_STEP * (trim - MCS_TRIM_RST))); // R9
        end
        if (cloop) begin
            gain = MCS_GAIN_FULL; // R10
        end
        prod = s * gain; // R7
        t = prod[MAG_W+11:12];
        r = neg ? -$signed({1'b0, t}) : $signed({1'b0, t});
        chan = inv ? -r : r; // R16
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait state on every access

    logic [31:0] ctrl_q;
    logic signed [CMD_W-1:0] cmd1_q, cmd2_q;
    logic ack_q;
    logic estop_q;
    logic tilt_acc_q;
    logic [2:0] tilt_sync_q, btn_p_q, btn_s_q, gpe_q, gpf_q;
    logic inv_q;

    wire req = (i_avs_read | i_avs_write) & ~ack_q;

    // acknowledge toggles so waitrequest drops for exactly one edge
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ack_q <= 1'b0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            ack_q <= req;
            o_avs_waitrequest <= ~req;
        end
    end

    // control and command registers written at the acknowledging edge
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctrl_q <= 32'h0;
            ctrl_q[MCS_CTL_TRIM1_LSB +: 4] <= MCS_TRIM_RST; // R8
            ctrl_q[MCS_CTL_TRIM2_LSB +: 4] <= MCS_TRIM_RST;
            ctrl_q[MCS_CTL_CURVE1_LSB +: 3] <= MCS_CURVE_RST; // R2
            ctrl_q[MCS_CTL_CURVE2_LSB +: 3] <= MCS_CURVE_RST;
            cmd1_q <= '0;
            cmd2_q <= '0;
        end else if (ack_q && i_avs_write) begin
            for (int b = 0; b < 4; b++) begin
                if (i_avs_byteenable[b]) begin
                    case (i_avs_address)
                        MCS_REG_CTRL: ctrl_q[8*b +: 8] <= i_avs_writedata[8*b +: 8]; // R1
                        default: ;
                    endcase
                end
            end
            if (i_avs_address == MCS_REG_CMD1) begin
                cmd1_q <= i_avs_writedata[CMD_W-1:0];
            end
            if (i_avs_address == MCS_REG_CMD2) begin
                cmd2_q <= i_avs_writedata[CMD_W-1:0];
            end
        end
    end

    // read mux, unmapped offsets read zero
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_avs_readdata <= 32'h0;
        end else if (req && i_avs_read) begin
            case (i_avs_address)
                MCS_REG_CTRL: o_avs_readdata <= ctrl_q;
                MCS_REG_CMD1: o_avs_readdata <= 32'(signed'(cmd1_q));
                MCS_REG_CMD2: o_avs_readdata <= 32'(signed'(cmd2_q));
                MCS_REG_STAT: o_avs_readdata <= {28'h0, o_power_en, inv_q, tilt_acc_q, estop_q};
                default: o_avs_readdata <= 32'h0;
            endcase
        end
    end

    // field views
    wire [2:0] curve1 = ctrl_q[MCS_CTL_CURVE1_LSB +: 3];
    wire [2:0] curve2 = ctrl_q[MCS_CTL_CURVE2_LSB +: 3];
    wire [3:0] trim1 = ctrl_q[MCS_CTL_TRIM1_LSB +: 4] > MCS_TRIM_MAX ? MCS_TRIM_MAX
                       : ctrl_q[MCS_CTL_TRIM1_LSB +: 4];
    wire [3:0] trim2 = ctrl_q[MCS_CTL_TRIM2_LSB +: 4] > MCS_TRIM_MAX ? MCS_TRIM_MAX
                       : ctrl_q[MCS_CTL_TRIM2_LSB +: 4];
    wire [1:0] safe_fn = ctrl_q[MCS_CTL_SAFE_LSB +: 2];
    wire [1:0] gpe_fn = ctrl_q[MCS_CTL_GPIE_LSB +: 2];
    wire [1:0] gpf_fn = ctrl_q[MCS_CTL_GPIF_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, three stages; only stages 2 and 3 are used

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tilt_sync_q <= 3'h0;
            btn_p_q <= 3'h7;
            btn_s_q <= 3'h7;
            gpe_q <= 3'h7;
            gpf_q <= 3'h7;
        end else begin
            tilt_sync_q <= {tilt_sync_q[1:0], i_safety_tilt_input};
            btn_p_q <= {btn_p_q[1:0], i_btn_prog_n};
            btn_s_q <= {btn_s_q[1:0], i_btn_set_n};
            gpe_q <= {gpe_q[1:0], i_gpi_e};
            gpf_q <= {gpf_q[1:0], i_gpi_f};
        end
    end

    // a level counts once stages two and three agree
    wire tilt_ok = tilt_sync_q[1] == tilt_sync_q[2];
    wire tilt_lv = tilt_sync_q[2];
    wire btns_both = ~btn_p_q[1] & ~btn_p_q[2] & ~btn_s_q[1] & ~btn_s_q[2];
    wire gpe_low = ~gpe_q[1] & ~gpe_q[2];
    wire gpf_low = ~gpf_q[1] & ~gpf_q[2];
    wire gpe_high = gpe_q[1] & gpe_q[2];
    wire gpf_high = gpf_q[1] & gpf_q[2];

    ////////////////////////////////////////////////////////////////////////
    // tilt qualification: new level must hold TILT_CYC cycles

    logic [CW-1:0] tilt_cnt_q;

    // any return to the accepted level restarts the wait
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            tilt_cnt_q <= '0;
            tilt_acc_q <= 1'b0;
        end else if (!tilt_ok || tilt_lv == tilt_acc_q) begin
            tilt_cnt_q <= '0; // R17
        end else if (tilt_cnt_q == CW'(TILT_CYC - 1)) begin
            tilt_cnt_q <= '0;
            tilt_acc_q <= tilt_lv; // R17
        end else begin
            tilt_cnt_q <= tilt_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // emergency stop latch, cleared only by reset

    mcs_stop_type stop_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            stop_q <= MCS_RUN;
        end else begin
            case (stop_q)
                MCS_RUN: begin
                    if (btns_both) begin
                        stop_q <= MCS_STOPPED; // R12
                    end else if (safe_fn == MCS_SAFE_ESTOP && tilt_ok && tilt_lv) begin
                        stop_q <= MCS_STOPPED; // R14
                    end
                end
                MCS_STOPPED: stop_q <= MCS_STOPPED; // R13
                default: stop_q <= MCS_STOPPED;
            endcase
        end
    end

    assign estop_q = (stop_q == MCS_STOPPED);

    ////////////////////////////////////////////////////////////////////////
    // inversion, general inputs, outputs

    wire inv_d = ctrl_q[MCS_CTL_MIXED_BIT] && safe_fn == MCS_SAFE_INVERT && tilt_acc_q; // R15
    wire gpe_on = !ctrl_q[MCS_CTL_ENC_BIT]; // R18
    wire aux_gpi = (gpe_on && gpe_fn == MCS_GPI_AUX && gpe_low)
                   || (gpf_fn == MCS_GPI_AUX && gpf_low); // R20
    wire gate_off = (gpe_on && gpe_fn == MCS_GPI_GATE && !gpe_low)
                    || (gpf_fn == MCS_GPI_GATE && !gpf_low); // R21
    wire run_any = ctrl_q[MCS_CTL_RUNOUT_BIT] && (i_mot1_run || i_mot2_run); // R11

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            inv_q <= 1'b0;
        end else begin
            inv_q <= inv_d;
        end
    end

    // aux output: software bit, motor-running option, or general input
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_aux_out <= 1'b0;
        end else begin
            o_aux_out <= ctrl_q[MCS_CTL_AUXSW_BIT] | run_any | aux_gpi; // R19
        end
    end

    // power and shaped commands; stop forces zero at once
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_power_en <= 1'b0;
            o_cmd1 <= '0;
            o_cmd2 <= '0;
            o_estop <= 1'b0;
        end else begin
            o_estop <= estop_q || btns_both;
            o_power_en <= !(estop_q || btns_both) && !gate_off; // R12
            o_cmd1 <= (estop_q || btns_both) ? '0
                      : chan(cmd1_q, curve1, trim1, ctrl_q[MCS_CTL_CLOOP1_BIT], inv_d);
            o_cmd2 <= (estop_q || btns_both) ? '0
                      : chan(cmd2_q, curve2, trim2, ctrl_q[MCS_CTL_CLOOP2_BIT], inv_d);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    a_estop_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R13
        o_estop |=> o_estop) else $error("estop released without reset");

    a_estop_power: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R12
        btns_both |=> !o_power_en && o_cmd1 == '0) else $error("buttons did not cut power");

    a_tilt_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R17
        $changed(tilt_acc_q) |-> $past(tilt_cnt_q) == CW'(TILT_CYC - 1))
        else $error("tilt accepted early");

    a_invert_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R15
        inv_q |-> $past(ctrl_q[MCS_CTL_MIXED_BIT]) && $past(safe_fn) == MCS_SAFE_INVERT)
        else $error("inversion outside mixed invert mode");

    a_gate_power: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R21
        gpf_fn == MCS_GPI_GATE && gpf_high && $stable(gpf_fn) |=> !o_power_en)
        else $error("gate input high but power on");

    a_enc_ignore: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R18
        ctrl_q[MCS_CTL_ENC_BIT] && gpf_fn == MCS_GPI_IGNORE && !estop_q && !btns_both
        && $stable(ctrl_q) ##1 $stable(ctrl_q) |-> o_power_en)
        else $error("input e acted with encoder fitted");

    a_run_aux: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R11
        run_any |=> o_aux_out) else $error("aux off while motor runs");

    a_lin_pass: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R3
        curve1 == MCS_CRV_LIN && trim1 == MCS_TRIM_RST && !inv_d && !estop_q && !btns_both
        && cmd1_q[CMD_W-1] == 1'b0 |=> o_cmd1 == $past(cmd1_q))
        else $error("linear curve altered command");

    a_trim_fwd: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R9
        curve1 == MCS_CRV_LIN && trim1 > MCS_TRIM_RST && !inv_d && !estop_q && !btns_both
        && !cmd1_q[CMD_W-1] |=> o_cmd1 == $past(cmd1_q))
        else $error("forward scaled by favouring trim");

    a_wait_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest held low");

    a_tilt_restart: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // R17
        !tilt_ok |=> tilt_cnt_q == '0) else $error("tilt wait not restarted");

    c_trim: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) trim1 == MCS_TRIM_MAX);
    c_estop: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(o_estop));
    c_tilt: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(tilt_acc_q));
    c_invert: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $rose(inv_q));
    c_gate: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) $fell(o_power_en));

endmodule

// *** rtl/mcs_pkg.sv ***
// package for the motor command shaping and safety block
// assumes one 100 MHz system clock and a synchronous active-high reset
package mcs_pkg;

    // register byte offsets on the avalon slave
    localparam logic [3:0] MCS_REG_CTRL = 4'h0;
    localparam logic [3:0] MCS_REG_CMD1 = 4'h4;
    localparam logic [3:0] MCS_REG_CMD2 = 4'h8;
    localparam logic [3:0] MCS_REG_STAT = 4'hC;

    // ctrl field positions
    localparam int MCS_CTL_CURVE1_LSB = 0;
    localparam int MCS_CTL_CURVE2_LSB = 3;
    localparam int MCS_CTL_TRIM1_LSB = 6;
    localparam int MCS_CTL_TRIM2_LSB = 10;
    localparam int MCS_CTL_SAFE_LSB = 14;
    localparam int MCS_CTL_GPIE_LSB = 16;
    localparam int MCS_CTL_GPIF_LSB = 18;
    localparam int MCS_CTL_RUNOUT_BIT = 20;
    localparam int MCS_CTL_MIXED_BIT = 21;
    localparam int MCS_CTL_CLOOP1_BIT = 22;
    localparam int MCS_CTL_CLOOP2_BIT = 23;
    localparam int MCS_CTL_ENC_BIT = 24;
    localparam int MCS_CTL_AUXSW_BIT = 25;

    // reset values and trim maximum
    localparam logic [2:0] MCS_CURVE_RST = 3'h0;
    localparam logic [3:0] MCS_TRIM_RST = 4'h7;
    localparam logic [3:0] MCS_TRIM_MAX = 4'hE;

    // tilt qualification time
    localparam int MCS_CLK_HZ = 100000000;
    localparam int MCS_TILT_MS = 500;
    localparam int MCS_TILT_CYC = MCS_CLK_HZ / 1000 * MCS_TILT_MS;

    // trim step is 0.75 percent of full gain 4096 = 30.72, rounded to 31
    localparam logic [12:0] MCS_GAIN_FULL = 13'h1000;
    localparam logic [12:0] MCS_TRIM_STEP = 13'h001F;

    typedef enum logic [2:0] {
        MCS_CRV_LIN = 3'b000,
        MCS_CRV_EXP_STRONG = 3'b001,
        MCS_CRV_EXP_NORMAL = 3'b010,
        MCS_CRV_LOG_NORMAL = 3'b011,
        MCS_CRV_LOG_STRONG = 3'b100
    } mcs_curve_type;

    typedef enum logic [1:0] {
        MCS_SAFE_NONE = 2'b00,
        MCS_SAFE_ESTOP = 2'b01,
        MCS_SAFE_INVERT = 2'b10
    } mcs_safe_type;

    typedef enum logic [1:0] {
        MCS_GPI_IGNORE = 2'b00,
        MCS_GPI_AUX = 2'b01,
        MCS_GPI_GATE = 2'b10
    } mcs_gpi_type;

    typedef enum logic [1:0] {
        MCS_RUN = 2'b00,
        MCS_STOPPED = 2'b01
    } mcs_stop_type;

endpackage

// *** dv/mcs_op_model.sv ***
// operator-side model: front buttons, tilt contact, general inputs, motor-run flags
// assumes the bench calls its tasks from one process; pins move just after a clock edge
`timescale 1ns/1ps

module mcs_op_model (
    input wire logic i_clk, // system clock
    output logic o_btn_prog_n, // front button, low pressed
    output logic o_btn_set_n, // front button, low pressed
    output logic o_tilt, // high = contact closed
    output logic o_gpi_e, // general input e
    output logic o_gpi_f, // general input f
    output logic o_mot1_run, // motor 1 running
    output logic o_mot2_run // motor 2 running
);

////////////////////////////////////////////////////////////////////////////////
// idle: buttons released and inputs pulled high, contact open, motors still
initial begin
    o_btn_prog_n = 1'b1;
    o_btn_set_n = 1'b1;
    o_tilt = 1'b0;
    o_gpi_e = 1'b1;
    o_gpi_f = 1'b1;
    o_mot1_run = 1'b0;
    o_mot2_run = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// pin tasks, each moves its pins right after an edge
task automatic btn(input logic prog_n, input logic set_n);
    @(posedge i_clk);
    o_btn_prog_n <= prog_n;
    o_btn_set_n <= set_n;
endtask

task automatic tilt(input logic closed);
    @(posedge i_clk);
    o_tilt <= closed;
endtask

task automatic gpi(input logic e, input logic f);
    @(posedge i_clk);
    o_gpi_e <= e;
    o_gpi_f <= f;
endtask

task automatic run(input logic m1, input logic m2);
    @(posedge i_clk);
    o_mot1_run <= m1;
    o_mot2_run <= m2;
endtask

// chattering contact: closes, opens briefly, closes again and stays closed
task automatic bounce(input int closed_n, input int open_n);
    @(posedge i_clk);
    o_tilt <= 1'b1;
    repeat (closed_n) @(posedge i_clk);
    o_tilt <= 1'b0;
    repeat (open_n) @(posedge i_clk);
    o_tilt <= 1'b1;
endtask

endmodule

// *** dv/tb.sv ***
// self-checking bench for the command shaping and safety block
// assumes the operator model on the pins and avalon accesses from one process
`timescale 1ns/1ps

module tb;
    import mcs_pkg::*;

localparam int TCYC = 20; // short tilt qualification for simulation
logic clk, rst, rd_s, wr_s, wait_s, aux, pwr, estop;
logic bp, bs, tl, ge, gf, m1, m2;
logic [3:0] addr;
logic [31:0] wdata, rdo, v;
logic signed [11:0] cmd1, cmd2;
logic signed [31:0] p[5], n[5], f[5], a, b, q;
int fail_count, checks_done, cyc;

////////////////////////////////////////////////////////////////////////////////
// clock, design and operator model
initial clk = 1'b0;
always #5 clk = ~clk;

mcs_top #(.TILT_CYC(TCYC), .CMD_W(12)) DUT (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdo), .o_avs_waitrequest(wait_s), .i_btn_prog_n(bp),
    .i_btn_set_n(bs), .i_safety_tilt_input(tl), .i_gpi_e(ge), .i_gpi_f(gf),
    .i_mot1_run(m1), .i_mot2_run(m2), .o_cmd1(cmd1), .o_cmd2(cmd2),
    .o_aux_out(aux), .o_power_en(pwr), .o_estop(estop));

mcs_op_model op (.i_clk(clk), .o_btn_prog_n(bp), .o_btn_set_n(bs), .o_tilt(tl),
    .o_gpi_e(ge), .o_gpi_f(gf), .o_mot1_run(m1), .o_mot2_run(m2));

////////////////////////////////////////////////////////////////////////////////
// helpers
task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
        fail_count++;
        $display("[FAIL] %0t %s", $time, msg);
    end
endtask

task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
endtask

// one access; request held until waitrequest is seen low at an edge
task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr_s <= w;
    rd_s <= !w;
    k = 0;
    do begin
        @(posedge clk);
        k++;
    end while (wait_s !== 1'b0 && k < 50);
    v = rdo;
    if (k >= 50) chk(1'b0, "bus access never answered");
    wr_s <= 1'b0;
    rd_s <= 1'b0;
endtask

// command 1 is written over the bus, then the registered output is sampled a few edges later
task automatic meas(input logic [11:0] c, output logic signed [31:0] o);
    bus(1'b1, MCS_REG_CMD1, {20'h0, c});
    settle(6);
    o = {{20{cmd1[11]}}, cmd1};
endtask

task automatic near(input logic signed [31:0] x, input logic signed [31:0] y,
        input string msg);
    chk(x - y <= 8192 && y - x <= 8192, msg);
endtask

function automatic logic [31:0] ctl(input int c1, t1, sf, ge_f, gf_f, ro, mx, cl, en);
    return 32'(c1 << MCS_CTL_CURVE1_LSB | t1 << MCS_CTL_TRIM1_LSB | 7 << MCS_CTL_TRIM2_LSB
        | sf << MCS_CTL_SAFE_LSB | ge_f << MCS_CTL_GPIE_LSB | gf_f << MCS_CTL_GPIF_LSB
        | ro << MCS_CTL_RUNOUT_BIT | mx << MCS_CTL_MIXED_BIT | cl << MCS_CTL_CLOOP1_BIT
        | en << MCS_CTL_ENC_BIT);
endfunction

task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle(3);
endtask

task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////
// hang guard, far above the expected run of under a thousand cycles
always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
        fail_count++;
        $display("[FAIL] %0t run did not complete", $time);
        tally_and_finish();
    end
end

////////////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    rst = 1'b1;
    rd_s = 1'b0;
    wr_s = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    do_reset();
    bus(1'b0, MCS_REG_CTRL, 32'h0);
    chk(v === ctl(0, 7, 0, 0, 0, 0, 0, 0, 0), "control reset value");
    bus(1'b0, MCS_REG_STAT, 32'h0);
    chk(v === 32'h8, "status after reset");
    bus(1'b0, 4'h2, 32'h0);
    chk(v === 32'h0, "unmapped read not zero");
    // every curve on channel 1 while channel 2 stays linear
    for (int c = 0; c < 5; c++) begin
        bus(1'b1, MCS_REG_CTRL, ctl(c, 7, 0, 0, 0, 0, 0, 0, 0));
        bus(1'b1, MCS_REG_CMD2, 32'h400);
        meas(12'h400, p[c]);
        meas(12'hC00, n[c]);
        meas(12'h7FF, f[c]);
        chk(p[c] > 0 && n[c] === -p[c], "curve not symmetric");
        chk({{20{cmd2[11]}}, cmd2} === p[0], "channel 2 followed channel 1");
        if (c < 3) chk(f[c] === f[0], "curve misses full output");
    end
    chk(p[1] < p[2] && p[2] < p[0], "exponential curves not below linear");
    chk(p[4] > p[3] && p[3] > p[0], "logarithmic curves not above linear");
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, 0, 0, 0, 0, 0, 0, 0));
    meas(12'h200, q);
    meas(12'h600, a);
    near((a - p[0]) * 4096, (p[0] - q) * 4096, "linear steps unequal");
    // whole trim range: forward slowed below 7, reverse slowed above 7
    for (int t = 0; t < 15; t++) begin
        bus(1'b1, MCS_REG_CTRL, ctl(0, t, 0, 0, 0, 0, 0, 0, 0));
        meas(12'h400, a);
        meas(12'hC00, b);
        if (t <= 7) begin
            chk(b === n[0], "reverse changed by trim");
            near(a * MCS_GAIN_FULL, p[0] * (MCS_GAIN_FULL - MCS_TRIM_STEP * (7 - t)),
                "forward gain wrong");
        end else begin
            chk(a === p[0], "forward changed by trim");
            near(-b * MCS_GAIN_FULL, p[0] * (MCS_GAIN_FULL - MCS_TRIM_STEP * (t - 7)),
                "reverse gain wrong");
        end
    end
    bus(1'b1, MCS_REG_CTRL, ctl(0, 0, 0, 0, 0, 0, 0, 1, 0));
    meas(12'h400, a);
    meas(12'hC00, b);
    chk(a === p[0] && b === n[0], "trim not bypassed in closed loop");
    // motor-running output
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, 0, 0, 0, 1, 0, 0, 0));
    op.run(1'b1, 1'b0);
    settle(6);
    chk(aux === 1'b1, "aux off with motor 1 running");
    op.run(1'b0, 1'b1);
    settle(6);
    chk(aux === 1'b1, "aux off with motor 2 running");
    op.run(1'b0, 1'b0);
    settle(6);
    chk(aux === 1'b0, "aux on with motors still");
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, 0, 0, 0, 0, 0, 0, 0));
    op.run(1'b1, 1'b1);
    settle(6);
    chk(aux === 1'b0, "aux on while option off");
    op.run(1'b0, 1'b0);
    // general inputs
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, 0, MCS_GPI_AUX, 0, 0, 0, 0, 0));
    op.gpi(1'b0, 1'b1);
    settle(6);
    chk(aux === 1'b1, "aux off with input low");
    op.gpi(1'b1, 1'b1);
    settle(6);
    chk(aux === 1'b0, "aux on with input high");
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, 0, MCS_GPI_AUX, 0, 0, 0, 0, 1));
    op.gpi(1'b0, 1'b1);
    settle(6);
    chk(aux === 1'b0, "input e used with encoder fitted");
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, 0, 0, MCS_GPI_GATE, 0, 0, 0, 0));
    op.gpi(1'b1, 1'b1);
    settle(6);
    chk(pwr === 1'b0, "power on with gate input high");
    op.gpi(1'b1, 1'b0);
    settle(6);
    chk(pwr === 1'b1, "power off with gate input low");
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, 0, 0, 0, 0, 0, 0, 0));
    op.gpi(1'b0, 1'b1);
    settle(6);
    chk(pwr === 1'b1 && aux === 1'b0, "ignored inputs acted");
    op.gpi(1'b1, 1'b1);
    // tilt inversion with a chattering contact
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, MCS_SAFE_INVERT, 0, 0, 0, 1, 0, 0));
    meas(12'h400, a);
    op.bounce(TCYC / 2, 2);
    settle(TCYC / 2 + 2);
    chk(cmd1 === p[0][11:0], "bounce accepted early");
    settle(TCYC + 6);
    chk(cmd1 === -p[0][11:0] && estop === 1'b0, "closed contact not inverting");
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, MCS_SAFE_INVERT, 0, 0, 0, 0, 0, 0));
    settle(6);
    chk(cmd1 === p[0][11:0], "inverted outside mixed mode");
    op.tilt(1'b0);
    // external stop switch
    bus(1'b1, MCS_REG_CTRL, ctl(0, 7, MCS_SAFE_ESTOP, 0, 0, 0, 0, 0, 0));
    settle(TCYC + 6);
    chk(estop === 1'b0, "stop with contact open");
    op.tilt(1'b1);
    settle(6);
    chk(estop === 1'b1 && pwr === 1'b0, "closed switch did not stop");
    op.tilt(1'b0);
    settle(10);
    chk(estop === 1'b1 && pwr === 1'b0, "stop released by switch");
    do_reset();
    chk(estop === 1'b0 && pwr === 1'b1, "reset did not clear stop");
    // front buttons: one alone does nothing, both stop at once
    meas(12'h400, a);
    op.btn(1'b0, 1'b1);
    settle(8);
    chk(estop === 1'b0, "single button stopped");
    op.btn(1'b0, 1'b0);
    settle(5);
    chk(estop === 1'b1 && pwr === 1'b0 && cmd1 === 12'h000, "buttons did not stop");
    op.btn(1'b1, 1'b1);
    meas(12'h400, a);
    settle(20);
    chk(estop === 1'b1 && cmd1 === 12'h000, "stop not latched");
    do_reset();
    chk(estop === 1'b0 && pwr === 1'b1, "reset did not clear stop");
    tally_and_finish();
end

endmodule
